// File: verilog/mrc_pkg.sv
package mrc_pkg;

  // opcodes taken from the serial link
  localparam logic [7:0]  OP_COMPUTE       = 8'h5B;
  localparam logic [7:0]  OP_PAUSE         = 8'h75;
  localparam logic [7:0]  OP_CONTINUE      = 8'h7A;

  // frame lengths in serial clock edges (single-lane)
  localparam logic [5:0]  FRAME_SHORT_BITS = 6'h08;
  localparam logic [5:0]  FRAME_LONG_BITS  = 6'h38;
  localparam logic [5:0]  FRAME_SAT_BITS   = 6'h3F;

  // frame field positions
  localparam int          OPC_SHORT_LSB    = 0;
  localparam int          OPC_LONG_LSB     = 48;
  localparam int          START_ADDR_LSB   = 24;
  localparam int          END_ADDR_LSB     = 0;
  localparam int          LINK_ADDR_W      = 24;

  // main array geometry
  localparam int          ARRAY_ADDR_W     = 18;
  localparam int          MIN_SPAN         = 3;

  // checksum
  localparam int          CRC_W            = 32;
  localparam logic [31:0] CRC_POLY         = 32'h1EDC6F41;
  localparam logic [31:0] CRC_RESET        = 32'h00000000;

  // timing
  localparam int          CLK_PERIOD_NS    = 50;
  localparam int          PAUSE_TIME_NS    = 400;
  localparam int          RESUME_TIME_NS   = 400;
  localparam int          PAUSE_CYCLES     = (PAUSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          RESUME_CYCLES    = (RESUME_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          TIMER_W          = 8;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'h0,
    ST_FETCH    = 3'h1,
    ST_LOAD     = 3'h2,
    ST_CALC     = 3'h3,
    ST_PAUSED   = 3'h4,
    ST_RESUMING = 3'h5
  } mrc_state_type;

  typedef struct packed {
    logic [5:0]  bitCount;
    logic [55:0] bits;
  } mrc_frame_type;

endpackage : mrc_pkg

// File: verilog/mrc_crc_byte_step.sv
`timescale 1ns/1ps
// one byte through the checksum, msb first, no reflection
module mrc_crc_byte_step #(
  parameter int               WIDTH = 32,
  parameter logic [WIDTH-1:0] POLY  = 32'h1EDC6F41
) (
  input  wire logic [WIDTH-1:0] crcIn,
  input  wire logic [7:0]       dataByte,
  output logic      [WIDTH-1:0] crcOut
);

  always_comb begin
    logic [WIDTH-1:0] acc;
    logic             fb;
    acc = crcIn;
    fb  = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      fb  = acc[WIDTH-1] ^ dataByte[i];
      acc = {acc[WIDTH-2:0], 1'b0} ^ (fb ? POLY : '0);
    end
    crcOut = acc;
  end

endmodule : mrc_crc_byte_step

// File: verilog/mrc_crc_engine.sv
`timescale 1ns/1ps
module mrc_crc_engine #(
  parameter int ADDR_W       = mrc_pkg::ARRAY_ADDR_W,
  parameter int PAUSE_CYCLES = mrc_pkg::PAUSE_CYCLES,
  parameter int RESUME_CYCLES = mrc_pkg::RESUME_CYCLES
) (
  input  wire logic                    core_clk,
  input  wire logic                    sys_rst,
  input  wire logic                    serialClk,
  input  wire logic                    chipSelN,
  input  wire logic                    serialIn,
  output logic      [ADDR_W-3:0]       memAddr,
  output logic                         memRdEn,
  input  wire logic [31:0]             memRdData,
  input  wire logic                    welSet,
  output logic                         welClear,
  input  wire logic                    softReset,
  input  wire logic                    deepSleep,
  output logic      [mrc_pkg::CRC_W-1:0] checksumResult,
  output logic                         workInProgressFlag,
  output logic                         pausedFlag,
  output logic                         abortFlag,
  output logic                         restrictCmds
);

  localparam logic [mrc_pkg::TIMER_W-1:0] PAUSE_LOAD  =
    mrc_pkg::TIMER_W'(PAUSE_CYCLES - 1);
  localparam logic [mrc_pkg::TIMER_W-1:0] RESUME_LOAD =
    mrc_pkg::TIMER_W'(RESUME_CYCLES - 1);

  // link side, on the serial clock
  mrc_pkg::mrc_frame_type frame_reg;
  mrc_pkg::mrc_frame_type frame_next;
  logic                   fresh_reg;

  // a new frame is marked while chip select is high; the preset is a constant
  always_ff @(posedge serialClk or posedge chipSelN) begin
    if (chipSelN) begin
      fresh_reg <= 1'b1;
    end else begin
      fresh_reg <= 1'b0;
    end
  end

  always_comb begin
    frame_next = frame_reg;
    if (fresh_reg) begin
      frame_next.bitCount = 6'h01;
      frame_next.bits     = {55'h0, serialIn};
    end else begin
      if (frame_reg.bitCount != mrc_pkg::FRAME_SAT_BITS) begin
        frame_next.bitCount = frame_reg.bitCount + 6'h01;
      end
      frame_next.bits = {frame_reg.bits[54:0], serialIn};
    end
  end

  // frame contents stay put after the frame, since the clock stops with chip select high
  always_ff @(posedge serialClk or posedge sys_rst) begin
    if (sys_rst) begin
      frame_reg <= '0;
    end else begin
      frame_reg <= frame_next;
    end
  end

  // crossing: chip select synchronised, frame read only after its rise
  logic                   csSync1_reg;
  logic                   csSync2_reg;
  logic                   csSync3_reg;
  logic                   csSync1_next;
  logic                   csSync2_next;
  logic                   csSync3_next;
  logic                   frameDone_reg;
  logic                   frameDone_next;
  mrc_pkg::mrc_frame_type hold_reg;
  mrc_pkg::mrc_frame_type hold_next;

  always_comb begin
    csSync1_next   = chipSelN;
    csSync2_next   = csSync1_reg;
    csSync3_next   = csSync2_reg;
    frameDone_next = csSync2_reg & ~csSync3_reg;
    hold_next      = hold_reg;
    if (frameDone_next) begin
      // several core cycles after the last serial edge, so the frame is stable
      hold_next = frame_reg;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      csSync1_reg   <= 1'b1;
      csSync2_reg   <= 1'b1;
      csSync3_reg   <= 1'b1;
      frameDone_reg <= 1'b0;
      hold_reg      <= '0;
    end else begin
      csSync1_reg   <= csSync1_next;
      csSync2_reg   <= csSync2_next;
      csSync3_reg   <= csSync3_next;
      frameDone_reg <= frameDone_next;
      hold_reg      <= hold_next;
    end
  end

  // command decode
  logic                          startCmd;
  logic                          pauseCmd;
  logic                          contCmd;
  logic [mrc_pkg::LINK_ADDR_W-1:0] linkStart;
  logic [mrc_pkg::LINK_ADDR_W-1:0] linkEnd;
  logic [ADDR_W-1:0]             reqStart;
  logic [ADDR_W-1:0]             reqEnd;

  always_comb begin
    linkStart = hold_reg.bits[mrc_pkg::START_ADDR_LSB +: mrc_pkg::LINK_ADDR_W];
    linkEnd   = hold_reg.bits[mrc_pkg::END_ADDR_LSB +: mrc_pkg::LINK_ADDR_W];
    // upper address bits fall outside the array and are ignored
    reqStart  = linkStart[ADDR_W-1:0];
    reqEnd    = linkEnd[ADDR_W-1:0];
    // a frame longer or shorter than exact is not executed
    startCmd  = frameDone_reg &&
                (hold_reg.bitCount == mrc_pkg::FRAME_LONG_BITS) &&
                (hold_reg.bits[mrc_pkg::OPC_LONG_LSB +: 8] == mrc_pkg::OP_COMPUTE);
    pauseCmd  = frameDone_reg &&
                (hold_reg.bitCount == mrc_pkg::FRAME_SHORT_BITS) &&
                (hold_reg.bits[mrc_pkg::OPC_SHORT_LSB +: 8] == mrc_pkg::OP_PAUSE);
    contCmd   = frameDone_reg &&
                (hold_reg.bitCount == mrc_pkg::FRAME_SHORT_BITS) &&
                (hold_reg.bits[mrc_pkg::OPC_SHORT_LSB +: 8] == mrc_pkg::OP_CONTINUE);
  end

  // engine
  mrc_pkg::mrc_state_type        state_reg;
  mrc_pkg::mrc_state_type        state_next;
  logic [ADDR_W-1:0]             byteAddr_reg;
  logic [ADDR_W-1:0]             byteAddr_next;
  logic [ADDR_W-1:0]             endAddr_reg;
  logic [ADDR_W-1:0]             endAddr_next;
  logic [31:0]                   word_reg;
  logic [31:0]                   word_next;
  logic [mrc_pkg::CRC_W-1:0]     result_reg;
  logic [mrc_pkg::CRC_W-1:0]     result_next;
  logic                          abort_reg;
  logic                          abort_next;
  logic                          pausePend_reg;
  logic                          pausePend_next;
  logic [mrc_pkg::TIMER_W-1:0]   timer_reg;
  logic [mrc_pkg::TIMER_W-1:0]   timer_next;
  logic                          welClear_reg;
  logic                          welClear_next;
  logic [7:0]                    laneByte;
  logic [mrc_pkg::CRC_W-1:0]     crcStep;
  logic                          running;

  // lane 0 is the lowest address and is shifted in first; it sits in the bottom byte of the word
  assign laneByte = word_reg[8*byteAddr_reg[1:0] +: 8];

  mrc_crc_byte_step #(
    .WIDTH (mrc_pkg::CRC_W),
    .POLY  (mrc_pkg::CRC_POLY)
  ) u_step (
    .crcIn    (result_reg),
    .dataByte (laneByte),
    .crcOut   (crcStep)
  );

  assign running = (state_reg == mrc_pkg::ST_FETCH) ||
                   (state_reg == mrc_pkg::ST_LOAD) ||
                   (state_reg == mrc_pkg::ST_CALC);

  always_comb begin
    state_next     = state_reg;
    byteAddr_next  = byteAddr_reg;
    endAddr_next   = endAddr_reg;
    word_next      = word_reg;
    result_next    = result_reg;
    abort_next     = abort_reg;
    pausePend_next = pausePend_reg;
    timer_next     = timer_reg;
    welClear_next  = 1'b0;
    if (deepSleep || softReset) begin
      state_next     = mrc_pkg::ST_IDLE;
      result_next    = mrc_pkg::CRC_RESET;
      pausePend_next = 1'b0;
    end else begin
      case (state_reg)
        mrc_pkg::ST_IDLE: begin
          if (startCmd) begin
            // write enable latch is not checked here
            result_next = mrc_pkg::CRC_RESET;
            abort_next  = 1'b0;
            if ({1'b0, reqEnd} < ({1'b0, reqStart} + (ADDR_W+1)'(mrc_pkg::MIN_SPAN))) begin
              abort_next = 1'b1;
            end else begin
              byteAddr_next = reqStart;
              endAddr_next  = reqEnd;
              state_next    = mrc_pkg::ST_FETCH;
            end
          end
        end
        mrc_pkg::ST_FETCH: begin
          state_next = mrc_pkg::ST_LOAD;
        end
        mrc_pkg::ST_LOAD: begin
          word_next  = memRdData;
          state_next = mrc_pkg::ST_CALC;
        end
        mrc_pkg::ST_CALC: begin
          result_next = crcStep;
          if (byteAddr_reg == endAddr_reg) begin
            // end byte is included before stopping
            state_next     = mrc_pkg::ST_IDLE;
            pausePend_next = 1'b0;
            welClear_next  = welSet;
          end else begin
            byteAddr_next = byteAddr_reg + ADDR_W'(1);
            if (byteAddr_reg[1:0] == 2'h3) begin
              state_next = mrc_pkg::ST_FETCH;
            end
          end
        end
        mrc_pkg::ST_PAUSED: begin
          if (contCmd) begin
            state_next = mrc_pkg::ST_RESUMING;
            timer_next = RESUME_LOAD;
          end
        end
        mrc_pkg::ST_RESUMING: begin
          if (timer_reg == '0) begin
            // refetch the word, since a pause may fall between lanes
            state_next = mrc_pkg::ST_FETCH;
          end else begin
            timer_next = timer_reg - mrc_pkg::TIMER_W'(1);
          end
        end
        default: begin
          state_next = mrc_pkg::ST_IDLE;
        end
      endcase
      // pause counts down while the work goes on, so a late finish wins
      if (running && (state_next != mrc_pkg::ST_IDLE)) begin
        if (pausePend_reg) begin
          if (timer_reg == '0) begin
            state_next     = mrc_pkg::ST_PAUSED;
            pausePend_next = 1'b0;
          end else begin
            timer_next = timer_reg - mrc_pkg::TIMER_W'(1);
          end
        end else if (pauseCmd) begin
          pausePend_next = 1'b1;
          timer_next     = PAUSE_LOAD;
        end
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg     <= mrc_pkg::ST_IDLE;
      byteAddr_reg  <= '0;
      endAddr_reg   <= '0;
      word_reg      <= '0;
      result_reg    <= mrc_pkg::CRC_RESET;
      abort_reg     <= 1'b0;
      pausePend_reg <= 1'b0;
      timer_reg     <= '0;
      welClear_reg  <= 1'b0;
    end else begin
      state_reg     <= state_next;
      byteAddr_reg  <= byteAddr_next;
      endAddr_reg   <= endAddr_next;
      word_reg      <= word_next;
      result_reg    <= result_next;
      abort_reg     <= abort_next;
      pausePend_reg <= pausePend_next;
      timer_reg     <= timer_next;
      welClear_reg  <= welClear_next;
    end
  end

  // outputs
  assign memAddr            = byteAddr_reg[ADDR_W-1:2];
  assign memRdEn            = (state_reg == mrc_pkg::ST_FETCH);
  assign checksumResult     = result_reg;
  assign welClear           = welClear_reg;
  // resuming counts as busy; paused and idle do not
  assign workInProgressFlag = running || (state_reg == mrc_pkg::ST_RESUMING);
  assign pausedFlag         = (state_reg == mrc_pkg::ST_PAUSED);
  assign abortFlag          = abort_reg;
  // the command decoder outside must reject all but reads, resets and continue
  assign restrictCmds       = (state_reg == mrc_pkg::ST_PAUSED);

endmodule : mrc_crc_engine

// File: verif/mrc_crc_engine_assertions.sv
`timescale 1ns/1ps
module mrc_crc_engine_assertions (
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic        memRdEn,
  input wire logic        welClear,
  input wire logic        softReset,
  input wire logic        deepSleep,
  input wire logic [31:0] checksumResult,
  input wire logic        workInProgressFlag,
  input wire logic        pausedFlag,
  input wire logic        restrictCmds
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  property p_excl; !(workInProgressFlag && pausedFlag); endproperty
  a_excl: assert property (p_excl) else $error("busy and paused together");
  property p_restrict; restrictCmds == pausedFlag; endproperty
  a_restrict: assert property (p_restrict) else $error("restrict differs");
  property p_welclr; welClear |-> !workInProgressFlag ##1 !welClear; endproperty
  a_welclr: assert property (p_welclr) else $error("latch clear misplaced");
  property p_soft; softReset |=> checksumResult == 32'h00000000 && !workInProgressFlag; endproperty
  a_soft: assert property (p_soft) else $error("soft reset kept result");
  property p_sleep; deepSleep |=> checksumResult == 32'h00000000 && !pausedFlag; endproperty
  a_sleep: assert property (p_sleep) else $error("sleep kept result");
  property p_rdpulse; memRdEn |-> workInProgressFlag ##1 !memRdEn; endproperty
  a_rdpulse: assert property (p_rdpulse) else $error("fetch not a pulse");
  property p_hold;
    pausedFlag && !softReset && !deepSleep |=> $stable(checksumResult);
  endproperty
  a_hold: assert property (p_hold) else $error("result moved while paused");
  property p_resume;
    $fell(pausedFlag) && !$past(softReset) && !$past(deepSleep) |-> workInProgressFlag;
  endproperty
  a_resume: assert property (p_resume) else $error("resume without busy");
  c_done: cover property ($fell(workInProgressFlag) && !pausedFlag);
  c_pause: cover property ($rose(pausedFlag));
  c_resume: cover property ($fell(pausedFlag) && workInProgressFlag);
endmodule : mrc_crc_engine_assertions

bind mrc_crc_engine mrc_crc_engine_assertions u_chk (.core_clk, .sys_rst, .memRdEn, .welClear,
  .softReset, .deepSleep, .checksumResult, .workInProgressFlag, .pausedFlag, .restrictCmds);

// File: verif/mrc_host_model.sv
`timescale 1ns/1ps
module mrc_host_model (
  input  wire logic        core_clk,
  input  wire logic [15:0] memAddr,
  input  wire logic        memRdEn,
  output logic      [31:0] memRdData,
  output logic             serialClk,
  output logic             chipSelN,
  output logic             serialIn
);
  logic held;
  initial begin
    serialClk = 1'b0;
    chipSelN  = 1'b1;
    serialIn  = 1'b0;
    memRdData = 32'h00000000;
    held      = 1'b0;
  end
  // word stays valid one cycle past the request, then scrambles so stale use shows
  always @(negedge core_clk) begin
    held <= memRdEn;
    if (memRdEn === 1'b1) begin
      for (int k = 0; k < 4; k++) begin
        memRdData[8*k+:8] <= {memAddr[5:0], k[1:0]} ^ 8'h5C;
      end
    end else if (!held) begin
      memRdData <= ~memRdData;
    end
  end
  // link clock idles low between frames; phase unrelated to the core clock
  task automatic send(input logic [55:0] f, input int n);
    #37;
    chipSelN = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      serialIn = f[i];
      #62.5 serialClk = 1'b1;
      #62.5 serialClk = 1'b0;
    end
    #62.5 chipSelN = 1'b1;
    serialIn = ~serialIn;
  endtask : send
endmodule : mrc_host_model

// File: verif/mrc_crc_engine_tb.sv
`timescale 1ns/1ps
module mrc_crc_engine_tb;
  logic        core_clk;
  logic        sys_rst;
  logic        serialClk;
  logic        chipSelN;
  logic        serialIn;
  logic [15:0] memAddr;
  logic        memRdEn;
  logic [31:0] memRdData;
  logic        welSet;
  logic        welClear;
  logic        softReset;
  logic        deepSleep;
  logic [31:0] checksumResult;
  logic        workInProgressFlag;
  logic        pausedFlag;
  logic        abortFlag;
  logic        restrictCmds;
  int          miscompares;
  int          total_checks;

  mrc_crc_engine #(.PAUSE_CYCLES(8), .RESUME_CYCLES(8)) u_dut (.core_clk, .sys_rst,
    .serialClk, .chipSelN, .serialIn, .memAddr, .memRdEn, .memRdData, .welSet, .welClear,
    .softReset, .deepSleep, .checksumResult, .workInProgressFlag, .pausedFlag, .abortFlag,
    .restrictCmds);
  mrc_host_model u_host (.core_clk, .memAddr, .memRdEn, .memRdData, .serialClk, .chipSelN,
    .serialIn);

  initial core_clk = 1'b0;
  always #25 core_clk = ~core_clk;
  always @(negedge core_clk) if (welClear === 1'b1) welSet <= 1'b0;

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic idle(input int n);
    repeat (n) @(negedge core_clk);
  endtask : idle

  task automatic flags(input logic [1:0] want, input int lim);
    int n;
    n = 0;
    while ({workInProgressFlag, pausedFlag} !== want && n < lim) begin
      @(negedge core_clk);
      n++;
    end
    check("flags", {30'h0, want}, {30'h0, workInProgressFlag, pausedFlag});
  endtask : flags

  function automatic logic [31:0] crc_of(input logic [23:0] sa, input logic [23:0] ea);
    logic [31:0] c;
    logic [7:0]  b;
    c = 32'h00000000;
    for (int a = sa; a <= ea; a++) begin
      b = a[7:0] ^ 8'h5C;
      for (int i = 7; i >= 0; i--) begin
        c = {c[30:0], 1'b0} ^ ((c[31] ^ b[i]) ? mrc_pkg::CRC_POLY : 32'h00000000);
      end
    end
    return c;
  endfunction : crc_of

  task automatic t_run(input logic [23:0] sa, input logic [23:0] ea);
    welSet = 1'b1;
    u_host.send({8'h5B, sa, ea}, 56);
    flags(2'b10, 20);
    flags(2'b00, 4000);
    idle(2);
    check("result", crc_of(sa, ea), checksumResult);
    check("abort", 32'h0, {31'h0, abortFlag});
    check("latch", 32'h0, {31'h0, welSet});
    $display("run %h to %h done", sa, ea);
  endtask : t_run

  task automatic t_bad;
    u_host.send(56'h005B0000000000, 48);
    idle(20);
    check("short", 32'h0, {30'h0, workInProgressFlag, pausedFlag});
    u_host.send({8'h5B, 24'h40, 24'h42}, 56);
    idle(20);
    check("abort", 32'h1, {31'h0, abortFlag});
    check("abort busy", 32'h0, {31'h0, workInProgressFlag});
    $display("refusals done");
  endtask : t_bad

  // pause taken a few cycles before the last byte: the finish must win and paused stays low
  task automatic t_late;
    u_host.send({8'h5B, 24'h100, 24'h113}, 56);
    flags(2'b10, 20);
    u_host.send(56'h75, 8);
    flags(2'b00, 40);
    idle(12);
    check("late stop", 32'h0, {31'h0, pausedFlag});
    check("late result", crc_of(24'h100, 24'h113), checksumResult);
    $display("late pause done");
  endtask : t_late

  task automatic t_pause;
    logic [31:0] held;
    u_host.send({8'h5B, 24'h0, 24'h3FF}, 56);
    flags(2'b10, 20);
    repeat (2) begin
      u_host.send(56'h75, 8);
      flags(2'b01, 40);
      check("restrict", 32'h1, {31'h0, restrictCmds});
      held = checksumResult;
      idle(30);
      check("held", held, checksumResult);
      u_host.send(56'h7A, 8);
      flags(2'b10, 20);
    end
    flags(2'b00, 4000);
    check("resumed", crc_of(24'h0, 24'h3FF), checksumResult);
    u_host.send(56'h7A, 8);
    idle(20);
    check("stray go", 32'h0, {31'h0, workInProgressFlag});
    u_host.send(56'h75, 8);
    idle(20);
    check("stray stop", 32'h0, {31'h0, pausedFlag});
    $display("pause done");
  endtask : t_pause

  task automatic t_cut;
    for (int i = 0; i < 2; i++) begin
      u_host.send({8'h5B, 24'h0, 24'h3FF}, 56);
      flags(2'b10, 20);
      idle(50);
      softReset = (i == 0);
      deepSleep = (i == 1);
      idle(1);
      softReset = 1'b0;
      deepSleep = 1'b0;
      idle(2);
      check("cut", 32'h0, checksumResult | {30'h0, workInProgressFlag, pausedFlag});
    end
    $display("cut done");
  endtask : t_cut

  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out

  initial begin
    miscompares = 0;
    total_checks = 0;
    sys_rst = 1'b1;
    welSet = 1'b0;
    softReset = 1'b0;
    deepSleep = 1'b0;
    idle(4);
    sys_rst = 1'b0;
    check("reset", 32'h0, checksumResult);
    idle(4);
    t_bad();
    t_run(24'h13, 24'h2A);
    t_run(24'h100, 24'h103);
    t_late();
    t_pause();
    t_cut();
    close_out();
  end

  // whole run needs well under 20000 cycles
  initial begin
    #2000000;
    miscompares++;
    close_out();
  end
endmodule : mrc_crc_engine_tb
